// ### inc/lgw_pkg.sv
package lgw_pkg;
    // register indices on the index/data port
    localparam logic [7:0] REG_GAMMA_POS_FINE_A  = 8'h30;
    localparam logic [7:0] REG_GAMMA_POS_FINE_B  = 8'h31;
    localparam logic [7:0] REG_GAMMA_POS_FINE_C  = 8'h32;
    localparam logic [7:0] REG_GAMMA_POS_FINE_D  = 8'h33;
    localparam logic [7:0] REG_GAMMA_POS_FINE_E  = 8'h34;
    localparam logic [7:0] REG_GAMMA_POS_GRAD    = 8'h35;
    localparam logic [7:0] REG_GAMMA_POS_AMPL    = 8'h36;
    localparam logic [7:0] REG_GAMMA_NEG_FINE_A  = 8'h37;
    localparam logic [7:0] REG_GAMMA_NEG_FINE_B  = 8'h38;
    localparam logic [7:0] REG_GAMMA_NEG_FINE_C  = 8'h39;
    localparam logic [7:0] REG_GAMMA_NEG_FINE_D  = 8'h3A;
    localparam logic [7:0] REG_GAMMA_NEG_FINE_E  = 8'h3B;
    localparam logic [7:0] REG_GAMMA_NEG_GRAD    = 8'h3C;
    localparam logic [7:0] REG_GAMMA_NEG_AMPL    = 8'h3D;
    localparam logic [7:0] REG_WINDOW_COL_START  = 8'h50;
    localparam logic [7:0] REG_WINDOW_COL_END    = 8'h51;
    localparam logic [7:0] REG_WINDOW_LINE_START = 8'h52;
    localparam logic [7:0] REG_WINDOW_LINE_END   = 8'h53;
    localparam logic [7:0] REG_GATE_SCAN_SETUP   = 8'h60;
    localparam logic [7:0] REG_BASE_IMAGE_CTRL   = 8'h61;
    localparam logic [7:0] REG_SCROLL_AMOUNT     = 8'h6A;
    localparam logic [7:0] REG_RAM_ADDR_LO       = 8'h20;
    localparam logic [7:0] REG_RAM_ADDR_HI       = 8'h21;
    localparam logic [7:0] REG_RAM_DATA          = 8'h22;
    // field positions
    localparam int FLD_SCAN_DIR  = 15;
    localparam int FLD_LINES_LSB = 8;
    localparam int FLD_NDL       = 2;
    localparam int FLD_SCROLL_EN = 1;
    localparam int FLD_INVERT    = 0;
    // reset values, line step and scroll limit
    localparam logic [7:0]  RST_WIN_COL_END  = 8'hEF;
    localparam logic [8:0]  RST_WIN_LINE_END = 9'h13F;
    localparam logic [8:0]  LINES_PER_STEP   = 9'h008;
    localparam logic [8:0]  SCROLL_MAX       = 9'h140;
    // timing: host strobe counter bases; strobe low WR_PULSE_CYC+2 cycles, high between phases WR_SETUP_CYC+4
    localparam int WR_SETUP_CYC = 1;
    localparam int WR_PULSE_CYC = 2;
endpackage : lgw_pkg

// ### inc/lgw_if.sv
`timescale 1ns/10ps
interface lgw_if;
    logic        index_data_select;
    logic        wr_n;
    logic [15:0] data;
    modport host (output index_data_select, output wr_n, output data);
    modport dev  (input index_data_select, input wr_n, input data);
endinterface : lgw_if

// ### hw/lgw_sync.sv
`timescale 1ns/10ps
module lgw_sync_pin #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    // a change is taken only once the second and third stages agree
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1  <= '1;
            s2  <= '1;
            s3  <= '1;
            q_o <= '1;
        end else if (ce_i) begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    q_o[i] <= s3[i];
                end
            end
        end
    end
endmodule : lgw_sync_pin

// ### hw/lgw_dev.sv
// How it works
// RULE1: hold 8-bit column window, clip writes
// RULE2: host keeps column bounds legal before writes
// RULE3: hold 9-bit line window, clip writes
// RULE4: host keeps line bounds legal before writes
// RULE5: six-bit scan start selects gate line
// RULE6: line count sets driven lines, eight-step
// RULE7: line count never alters RAM mapping
// RULE8: host sets line count covering panel
// RULE9: one bit selects gate scan direction
// RULE10: invert bit swaps zero-data drive levels
// RULE11: porch level follows separate porch setting
// RULE12: scroll enable shifts base image start
// RULE13: nine-bit scroll amount offsets start line
// RULE14: scrolling leaves partial images in place
// RULE15: host keeps scroll off on external interface; lgw_host ties ext_if_mode to 0, lgw_dev forces start line 0 instead
// RULE16: non-display bit sets unlit area level
// RULE17: positive gamma fine, gradient, amplitude fields
// RULE18: identical independent negative gamma fields
// RULE19: ram writes advance address, reads never
// RULE20: host keeps scroll amount within 320
// RULE21: fixed-zero bits ignored on write
`timescale 1ns/10ps
module lgw_dev
    import lgw_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        CE_I,
    lgw_if.dev               bus,
    input  wire logic        PORCH_LEVEL_SEL_I,
    input  wire logic        EXT_IF_ACTIVE_I,
    output logic [17:0]      GAMMA_POS_FINE_3B_O,
    output logic [7:0]       GAMMA_POS_FINE_2B_O,
    output logic [5:0]       GAMMA_POS_GRADIENT_SEL_O,
    output logic [9:0]       GAMMA_POS_AMPLITUDE_SEL_O,
    output logic [17:0]      GAMMA_NEG_FINE_3B_O,
    output logic [7:0]       GAMMA_NEG_FINE_2B_O,
    output logic [5:0]       GAMMA_NEG_GRADIENT_SEL_O,
    output logic [9:0]       GAMMA_NEG_AMPLITUDE_SEL_O,
    output logic [5:0]       SCAN_START_LINE_O,
    output logic [8:0]       DRIVEN_LINES_O,
    output logic             GATE_SCAN_DIR_O,
    output logic             ZERO_LEVEL_POS_HIGH_O,
    output logic             PORCH_LEVEL_SEL_O,
    output logic             NONDISPLAY_LEVEL_O,
    output logic [8:0]       DISPLAY_START_LINE_O,
    output logic [16:0]      RAM_ADDR_O,
    output logic [17:0]      RAM_WDATA_O,
    output logic             RAM_WE_O
);
    logic        sel_q;
    logic        wr_n_q;
    logic [15:0] data_hold;
    logic [5:0]  fld3;
    logic [3:0]  fld2;
    logic [9:0]  fld5;
    logic        wr_n_d;
    logic        wr_rise;
    logic [7:0]  index;
    logic [7:0]  win_col_start;
    logic [7:0]  win_col_end;
    logic [8:0]  win_line_start;
    logic [8:0]  win_line_end;
    logic [5:0]  driven_line_count;
    logic        gray_invert;
    logic        scroll_enable;
    logic [8:0]  scroll_amount;
    logic [7:0]  col;
    logic [8:0]  line;
    logic        data_wr;

    // data bus is stable around the strobe, so only controls take the filter
    lgw_sync_pin #(.WIDTH(2)) u_sync (
        .clk_i   (REF_CLK_I),
        .arst_n_i(ARST_N_I),
        .ce_i    (CE_I),
        .d_i     ({bus.index_data_select, bus.wr_n}),
        .q_o     ({sel_q, wr_n_q})
    );
    assign fld3    = {data_hold[10:8], data_hold[2:0]};
    assign fld2    = {data_hold[9:8], data_hold[1:0]};
    assign fld5    = {data_hold[12:8], data_hold[4:0]};
    assign wr_rise = wr_n_q && !wr_n_d;
    assign data_wr = wr_rise && sel_q;

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_n_d    <= 1'b1;
            data_hold <= 16'h0000;
        end else if (CE_I) begin
            wr_n_d    <= wr_n_q;
            data_hold <= bus.data;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            index <= 8'h00;
        end else if (CE_I && wr_rise && !sel_q) begin
            index <= data_hold[7:0];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            GAMMA_POS_FINE_3B_O       <= 18'h00000;
            GAMMA_POS_FINE_2B_O       <= 8'h00;
            GAMMA_POS_GRADIENT_SEL_O  <= 6'h00;
            GAMMA_POS_AMPLITUDE_SEL_O <= 10'h000;
            GAMMA_NEG_FINE_3B_O       <= 18'h00000;
            GAMMA_NEG_FINE_2B_O       <= 8'h00;
            GAMMA_NEG_GRADIENT_SEL_O  <= 6'h00;
            GAMMA_NEG_AMPLITUDE_SEL_O <= 10'h000;
        end else if (CE_I && data_wr) begin
            case (index)
                REG_GAMMA_POS_FINE_A: GAMMA_POS_FINE_3B_O[5:0]   <= fld3; // [RULE17] [RULE21]
                REG_GAMMA_POS_FINE_B: GAMMA_POS_FINE_3B_O[11:6]  <= fld3; // [RULE17]
                REG_GAMMA_POS_FINE_C: GAMMA_POS_FINE_3B_O[17:12] <= fld3; // [RULE17]
                REG_GAMMA_POS_FINE_D: GAMMA_POS_FINE_2B_O[3:0]   <= fld2; // [RULE17]
                REG_GAMMA_POS_FINE_E: GAMMA_POS_FINE_2B_O[7:4]   <= fld2; // [RULE17]
                REG_GAMMA_POS_GRAD:   GAMMA_POS_GRADIENT_SEL_O   <= fld3; // [RULE17]
                REG_GAMMA_POS_AMPL:   GAMMA_POS_AMPLITUDE_SEL_O  <= fld5; // [RULE17]
                REG_GAMMA_NEG_FINE_A: GAMMA_NEG_FINE_3B_O[5:0]   <= fld3; // [RULE18]
                REG_GAMMA_NEG_FINE_B: GAMMA_NEG_FINE_3B_O[11:6]  <= fld3; // [RULE18]
                REG_GAMMA_NEG_FINE_C: GAMMA_NEG_FINE_3B_O[17:12] <= fld3; // [RULE18]
                REG_GAMMA_NEG_FINE_D: GAMMA_NEG_FINE_2B_O[3:0]   <= fld2; // [RULE18]
                REG_GAMMA_NEG_FINE_E: GAMMA_NEG_FINE_2B_O[7:4]   <= fld2; // [RULE18]
                REG_GAMMA_NEG_GRAD:   GAMMA_NEG_GRADIENT_SEL_O   <= fld3; // [RULE18]
                REG_GAMMA_NEG_AMPL:   GAMMA_NEG_AMPLITUDE_SEL_O  <= fld5; // [RULE18]
                default: ;
            endcase
        end
    end

    // window and base-image setup
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            win_col_start     <= 8'h00;
            win_col_end       <= RST_WIN_COL_END;
            win_line_start    <= 9'h000;
            win_line_end      <= RST_WIN_LINE_END;
            SCAN_START_LINE_O <= 6'h00;
            driven_line_count <= 6'h00;
            GATE_SCAN_DIR_O   <= 1'b0;
            gray_invert       <= 1'b0;
            scroll_enable     <= 1'b0;
            NONDISPLAY_LEVEL_O <= 1'b0;
            scroll_amount     <= 9'h000;
        end else if (CE_I && data_wr) begin
            case (index)
                REG_WINDOW_COL_START:  win_col_start  <= data_hold[7:0]; // [RULE1]
                REG_WINDOW_COL_END:    win_col_end    <= data_hold[7:0]; // [RULE1]
                REG_WINDOW_LINE_START: win_line_start <= data_hold[8:0]; // [RULE3]
                REG_WINDOW_LINE_END:   win_line_end   <= data_hold[8:0]; // [RULE3]
                REG_GATE_SCAN_SETUP: begin
                    SCAN_START_LINE_O <= data_hold[5:0]; // [RULE5]
                    driven_line_count <= data_hold[FLD_LINES_LSB+:6]; // [RULE6]
                    GATE_SCAN_DIR_O   <= data_hold[FLD_SCAN_DIR]; // [RULE9]
                end
                REG_BASE_IMAGE_CTRL: begin
                    gray_invert        <= data_hold[FLD_INVERT]; // [RULE10]
                    scroll_enable      <= data_hold[FLD_SCROLL_EN]; // [RULE12]
                    NONDISPLAY_LEVEL_O <= data_hold[FLD_NDL]; // [RULE16]
                end
                REG_SCROLL_AMOUNT: scroll_amount <= data_hold[8:0]; // [RULE13]
                default: ;
            endcase
        end
    end

    // partial images take nothing from here
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            DRIVEN_LINES_O        <= 9'h000;
            ZERO_LEVEL_POS_HIGH_O <= 1'b1;
            PORCH_LEVEL_SEL_O     <= 1'b0;
            DISPLAY_START_LINE_O  <= 9'h000;
        end else if (CE_I) begin
            // count n drives n+1 steps; ram mapping untouched [RULE7]
            DRIVEN_LINES_O        <= (9'(driven_line_count) + 9'h001) * LINES_PER_STEP; // [RULE6]
            ZERO_LEVEL_POS_HIGH_O <= !gray_invert; // [RULE10]
            PORCH_LEVEL_SEL_O     <= PORCH_LEVEL_SEL_I; // [RULE11]
            // external interface guard [RULE15]
            DISPLAY_START_LINE_O  <= (scroll_enable && !EXT_IF_ACTIVE_I && scroll_amount <= SCROLL_MAX)
                                     ? scroll_amount : 9'h000; // [RULE12] [RULE14]
        end
    end

    // address counter: column then line, wraps inside the window
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            col         <= 8'h00;
            line        <= 9'h000;
            RAM_ADDR_O  <= 17'h00000;
            RAM_WDATA_O <= 18'h00000;
            RAM_WE_O    <= 1'b0;
        end else if (CE_I) begin
            RAM_WE_O <= 1'b0;
            if (data_wr && index == REG_RAM_ADDR_LO) begin
                col <= data_hold[7:0];
            end else if (data_wr && index == REG_RAM_ADDR_HI) begin
                line <= data_hold[8:0];
            end else if (data_wr && index == REG_RAM_DATA) begin
                // writes outside the window are dropped [RULE1] [RULE3]
                if (col >= win_col_start && col <= win_col_end &&
                    line >= win_line_start && line <= win_line_end) begin
                    RAM_WE_O    <= 1'b1;
                    RAM_ADDR_O  <= {line, col};
                    RAM_WDATA_O <= {data_hold[15:11], data_hold[15], data_hold[10:5],
                                    data_hold[4:0], data_hold[4]};
                end
                if (col >= win_col_end) begin // [RULE19]
                    col  <= win_col_start;
                    line <= (line >= win_line_end) ? win_line_start : line + 9'h001;
                end else begin
                    col <= col + 8'h01;
                end
            end
        end
    end
endmodule : lgw_dev

// ### hw/lgw_host.sv
`timescale 1ns/10ps
module lgw_host
    import lgw_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        CE_I,
    input  wire logic        REQ_I,
    input  wire logic [7:0]  REQ_INDEX_I,
    input  wire logic [15:0] REQ_DATA_I,
    output logic             BUSY_O,
    output logic             DONE_O,
    output logic             REJECT_O,
    lgw_if.host              bus
);
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} lgw_hst_type;
    lgw_hst_type state;
    logic        phase;
    logic [1:0]  cnt;
    logic [7:0]  idx;
    logic [15:0] dat;
    logic        sel;
    logic        wr_n;
    logic        legal;
    logic        ext_if_mode;
    logic [7:0]  col_start;
    logic [8:0]  line_start;

    assign bus.index_data_select = sel;
    assign bus.wr_n = wr_n;
    assign bus.data = phase ? dat : {8'h00, idx};
    assign ext_if_mode = 1'b0;

    always_comb begin
        legal = 1'b1;
        case (REQ_INDEX_I)
            REG_WINDOW_COL_END:
                legal = REQ_DATA_I[7:0] <= RST_WIN_COL_END && REQ_DATA_I[7:0] > col_start
                        && (REQ_DATA_I[7:0] - col_start) >= 8'h04; // [RULE2]
            REG_WINDOW_LINE_END:
                legal = REQ_DATA_I[8:0] <= RST_WIN_LINE_END
                        && REQ_DATA_I[8:0] > line_start; // [RULE4]
            REG_GATE_SCAN_SETUP:
                legal = REQ_DATA_I[13:8] >= 6'h1D && REQ_DATA_I[13:8] <= 6'h27; // [RULE8]
            REG_BASE_IMAGE_CTRL:
                legal = !(ext_if_mode && REQ_DATA_I[FLD_SCROLL_EN]); // [RULE15]
            REG_SCROLL_AMOUNT:
                legal = REQ_DATA_I[8:0] <= SCROLL_MAX; // [RULE20]
            default: legal = 1'b1;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            col_start  <= 8'h00;
            line_start <= 9'h000;
        end else if (CE_I && REQ_I && state == ST_IDLE && legal) begin
            if (REQ_INDEX_I == REG_WINDOW_COL_START) col_start <= REQ_DATA_I[7:0];
            if (REQ_INDEX_I == REG_WINDOW_LINE_START) line_start <= REQ_DATA_I[8:0];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= ST_IDLE;
            phase <= 1'b0;
            cnt <= 2'd0;
            idx <= 8'h00;
            dat <= 16'h0000;
            sel <= 1'b0;
            wr_n <= 1'b1;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
            REJECT_O <= 1'b0;
        end else if (CE_I) begin
            DONE_O <= 1'b0;
            REJECT_O <= 1'b0;
            case (state)
                ST_IDLE: if (REQ_I) begin
                    if (legal) begin
                        idx <= REQ_INDEX_I;
                        dat <= REQ_DATA_I;
                        phase <= 1'b0;
                        sel <= 1'b0;
                        cnt <= 2'd0;
                        BUSY_O <= 1'b1;
                        state <= ST_SETUP;
                    end else begin
                        REJECT_O <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    wr_n <= 1'b0;
                    cnt <= 2'd0;
                    state <= ST_PULSE;
                end
                ST_PULSE: begin
                    if (cnt == 2'(WR_PULSE_CYC + 1)) begin
                        wr_n <= 1'b1;
                        cnt <= 2'd0;
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt + 2'd1;
                    end
                end
                ST_HOLD: begin
                    if (cnt == 2'(WR_SETUP_CYC + 2)) begin
                        if (phase) begin
                            BUSY_O <= 1'b0;
                            DONE_O <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            phase <= 1'b1;
                            sel <= 1'b1;
                            state <= ST_SETUP;
                        end
                    end else begin
                        cnt <= cnt + 2'd1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule : lgw_host

// ### test/lgw_bus_asserts.sv
`timescale 1ns/10ps
module lgw_bus_asserts
    import lgw_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        index_data_select,
    input  wire logic        wr_n,
    input  wire logic [15:0] data
);
    logic [7:0] last_idx;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            last_idx <= 8'h00;
        end else if ($rose(wr_n) && !index_data_select) begin
            last_idx <= data[7:0];
        end
    end
    sequence s_strobe;
        !wr_n [*4] ##1 wr_n;
    endsequence
    sequence s_data_phase;
        ##[1:8] ($fell(wr_n) && index_data_select);
    endsequence
    sequence s_data_to(logic [7:0] idx);
        $fell(wr_n) && index_data_select && (last_idx == idx);
    endsequence
    property p_strobe_width;
        $fell(wr_n) |-> s_strobe;
    endproperty
    property p_data_hold;
        !wr_n |-> $stable(data);
    endproperty
    property p_sel_hold;
        !wr_n |-> $stable(index_data_select);
    endproperty
    property p_index_then_data;
        $rose(wr_n) && !index_data_select |-> s_data_phase;
    endproperty
    property p_col_end;
        s_data_to(REG_WINDOW_COL_END) |-> data[7:0] <= 8'hEF;
    endproperty
    property p_line_end;
        s_data_to(REG_WINDOW_LINE_END) |-> data[8:0] <= 9'h13F;
    endproperty
    property p_scroll;
        s_data_to(REG_SCROLL_AMOUNT) |-> data[8:0] <= SCROLL_MAX;
    endproperty
    property p_lines;
        s_data_to(REG_GATE_SCAN_SETUP) |-> data[13:8] inside {[6'h1D:6'h27]};
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("write strobe width wrong");
    a_data_hold: assert property (p_data_hold)
        else $error("data moved under strobe");
    a_sel_hold: assert property (p_sel_hold)
        else $error("select moved under strobe");
    a_index_then_data: assert property (p_index_then_data)
        else $error("index phase without data phase");
    a_col_end: assert property (p_col_end)
        else $error("column end beyond limit");
    a_line_end: assert property (p_line_end)
        else $error("line end beyond limit");
    a_scroll: assert property (p_scroll)
        else $error("scroll amount beyond limit");
    a_lines: assert property (p_lines)
        else $error("inhibited line count sent");
endmodule : lgw_bus_asserts

// ### test/tb_lcd_gamma_window_scroll_regs.sv
`timescale 1ns/10ps
module tb_lcd_gamma_window_scroll_regs
    import lgw_pkg::*;
;
    typedef struct {logic [7:0] idx; logic [15:0] dat; int sel; logic [17:0] exp;} lgw_row_type;
    logic        ref_clk, arst_n, ce, req, done, reject, porch_sel, ext_if;
    logic [7:0]  req_index, pos_f2, neg_f2;
    logic [15:0] req_data;
    logic [17:0] pos_f3, neg_f3, ram_wdata;
    logic [5:0]  pos_gr, neg_gr, scan_start;
    logic [9:0]  pos_am, neg_am;
    logic [8:0]  lines, start_line, bad_start;
    logic        dir, zero_hi, porch_o, nondisplay_level, ram_we, prev_wr;
    logic [16:0] ram_addr, last_addr;
    int          bad_count = 0, num_checks = 0, we_cnt = 0, strobe_cnt = 0, cyc = 0;
    lgw_if bus_if ();
    lgw_if bad_if ();
    lgw_host lgw_host_inst (.REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .CE_I(ce), .REQ_I(req),
        .REQ_INDEX_I(req_index), .REQ_DATA_I(req_data), .BUSY_O(), .DONE_O(done),
        .REJECT_O(reject), .bus(bus_if.host));
    lgw_dev lgw_dev_inst (.REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .CE_I(ce), .bus(bus_if.dev),
        .PORCH_LEVEL_SEL_I(porch_sel), .EXT_IF_ACTIVE_I(ext_if), .GAMMA_POS_FINE_3B_O(pos_f3),
        .GAMMA_POS_FINE_2B_O(pos_f2), .GAMMA_POS_GRADIENT_SEL_O(pos_gr),
        .GAMMA_POS_AMPLITUDE_SEL_O(pos_am), .GAMMA_NEG_FINE_3B_O(neg_f3),
        .GAMMA_NEG_FINE_2B_O(neg_f2), .GAMMA_NEG_GRADIENT_SEL_O(neg_gr),
        .GAMMA_NEG_AMPLITUDE_SEL_O(neg_am), .SCAN_START_LINE_O(scan_start),
        .DRIVEN_LINES_O(lines), .GATE_SCAN_DIR_O(dir), .ZERO_LEVEL_POS_HIGH_O(zero_hi),
        .PORCH_LEVEL_SEL_O(porch_o), .NONDISPLAY_LEVEL_O(nondisplay_level), .DISPLAY_START_LINE_O(start_line),
        .RAM_ADDR_O(ram_addr), .RAM_WDATA_O(ram_wdata), .RAM_WE_O(ram_we));
    // bench drives this one directly to bypass host limits
    lgw_dev lgw_dev_bad_inst (.REF_CLK_I(ref_clk), .ARST_N_I(arst_n), .CE_I(ce),
        .bus(bad_if.dev), .PORCH_LEVEL_SEL_I(porch_sel), .EXT_IF_ACTIVE_I(ext_if),
        .GAMMA_POS_FINE_3B_O(), .GAMMA_POS_FINE_2B_O(), .GAMMA_POS_GRADIENT_SEL_O(),
        .GAMMA_POS_AMPLITUDE_SEL_O(), .GAMMA_NEG_FINE_3B_O(), .GAMMA_NEG_FINE_2B_O(),
        .GAMMA_NEG_GRADIENT_SEL_O(), .GAMMA_NEG_AMPLITUDE_SEL_O(), .SCAN_START_LINE_O(),
        .DRIVEN_LINES_O(), .GATE_SCAN_DIR_O(), .ZERO_LEVEL_POS_HIGH_O(), .PORCH_LEVEL_SEL_O(),
        .NONDISPLAY_LEVEL_O(), .DISPLAY_START_LINE_O(bad_start), .RAM_ADDR_O(), .RAM_WDATA_O(),
        .RAM_WE_O());
    lgw_bus_asserts lgw_bus_asserts_inst (.REF_CLK_I(ref_clk), .ARST_N_I(arst_n),
        .index_data_select(bus_if.index_data_select), .wr_n(bus_if.wr_n), .data(bus_if.data));
    lgw_row_type rows [0:26] = '{
        '{8'h30, 16'hFDFB, 0, 18'h0002B}, '{8'h3A, 16'hFFFE, 1, 18'h0000E},
        '{8'h35, 16'h0604, 2, 18'h00034}, '{8'h36, 16'hFFE1, 3, 18'h003E1},
        '{8'h3D, 16'h0A15, 4, 18'h00155}, '{8'h3C, 16'h0102, 5, 18'h0000A},
        '{8'h39, 16'h0407, 6, 18'h27000}, '{8'h60, 16'hE7C5, 7, 18'h00140},
        '{8'h60, 16'h1D27, 8, 18'h00027}, '{8'h60, 16'h9D00, 9, 18'h00001},
        '{8'h61, 16'hFFF9, 10, 18'h00000}, '{8'h61, 16'h0004, 11, 18'h00001},
        '{8'h6A, 16'h0140, 12, 18'h00000}, '{8'h61, 16'h0002, 12, 18'h00140},
        '{8'h6A, 16'h0005, 12, 18'h00005}, '{8'h61, 16'h0000, 12, 18'h00000},
        '{8'h50, 16'h0010, 13, 18'h00000}, '{8'h51, 16'h0014, 13, 18'h00000},
        '{8'h52, 16'h0005, 13, 18'h00000}, '{8'h53, 16'h0006, 13, 18'h00000},
        '{8'h20, 16'h0010, 13, 18'h00000}, '{8'h21, 16'h0005, 13, 18'h00000},
        '{8'h22, 16'h1234, 14, 18'h00510}, '{8'h20, 16'h0020, 13, 18'h00001},
        '{8'h22, 16'h0001, 13, 18'h00001}, '{8'h21, 16'h0007, 13, 18'h00001},
        '{8'h22, 16'h0001, 13, 18'h00001}};
    logic [23:0] refused [0:4] = '{24'h5100F0, 24'h510013, 24'h6A0141, 24'h602800, 24'h530140};
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // negedge sampling avoids racing the launching edge
    always @(negedge ref_clk) begin
        if (ram_we === 1'b1) begin
            we_cnt++;
            last_addr = ram_addr;
        end
        if (prev_wr === 1'b1 && bus_if.wr_n === 1'b0) strobe_cnt++;
        prev_wr = bus_if.wr_n;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            $display("MISMATCH %0t run did not finish", $time);
            report_and_stop();
        end
    end
    function automatic logic [17:0] get_out(input int sel);
        case (sel)
            0: return pos_f3;
            1: return 18'(neg_f2);
            2: return 18'(pos_gr);
            3: return 18'(pos_am);
            4: return 18'(neg_am);
            5: return 18'(neg_gr);
            6: return neg_f3;
            7: return 18'(lines);
            8: return 18'(scan_start);
            9: return 18'(dir);
            10: return 18'(zero_hi);
            11: return 18'(nondisplay_level);
            12: return 18'(start_line);
            13: return 18'(we_cnt);
            default: return 18'(last_addr);
        endcase
    endfunction : get_out
    task automatic check_val(input logic [17:0] got, input logic [17:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_val
    task automatic do_req(input logic [7:0] idx, input logic [15:0] dat, output logic rej);
        int n = 0;
        @(posedge ref_clk);
        #2;
        req = 1'b1;
        req_index = idx;
        req_data = dat;
        @(posedge ref_clk);
        #2;
        req = 1'b0;
        while (n < 40 && done !== 1'b1 && reject !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        rej = (reject === 1'b1);
        if (n == 40) check_val(18'h00000, 18'h00001, "no answer from host");
        repeat (6) @(posedge ref_clk);
        #2;
    endtask : do_req
    task automatic bad_phase(input logic sel, input logic [15:0] val);
        @(posedge ref_clk);
        #2;
        bad_if.index_data_select = sel;
        bad_if.data = val;
        @(posedge ref_clk);
        #2;
        bad_if.wr_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #2;
        bad_if.wr_n = 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask : bad_phase
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        logic rej;
        int   s;
        {arst_n, req, req_index, req_data, porch_sel, ext_if} = '0;
        ce = 1'b1;
        bad_if.index_data_select = 1'b0;
        bad_if.wr_n = 1'b1;
        bad_if.data = 16'h0000;
        repeat (6) @(posedge ref_clk);
        #2;
        arst_n = 1'b1;
        check_val(18'(zero_hi), 18'h00001, "reset zero level");
        check_val(pos_f3, 18'h00000, "reset fine gamma");
        foreach (rows[i]) begin
            do_req(rows[i].idx, rows[i].dat, rej);
            check_val(get_out(rows[i].sel), rows[i].exp, "table row");
        end
        foreach (refused[i]) begin
            s = strobe_cnt;
            do_req(refused[i][23:16], refused[i][15:0], rej);
            check_val(18'(rej), 18'h00001, "illegal value accepted");
            check_val(18'(strobe_cnt - s), 18'h00000, "refused value reached bus");
        end
        do_req(REG_BASE_IMAGE_CTRL, 16'h0002, rej);
        ext_if = 1'b1;
        porch_sel = 1'b1;
        repeat (4) @(posedge ref_clk);
        #2;
        check_val(18'(start_line), 18'h00000, "scroll under external interface");
        check_val(18'(porch_o), 18'h00001, "porch level");
        ext_if = 1'b0;
        bad_phase(1'b0, 16'(REG_BASE_IMAGE_CTRL));
        bad_phase(1'b1, 16'h0002);
        bad_phase(1'b0, 16'(REG_SCROLL_AMOUNT));
        bad_phase(1'b1, 16'h0003);
        check_val(18'(bad_start), 18'h00003, "direct scroll");
        bad_phase(1'b0, 16'(REG_SCROLL_AMOUNT));
        bad_phase(1'b1, 16'h0141);
        check_val(18'(bad_start), 18'h00000, "oversized scroll");
        do_req(REG_BASE_IMAGE_CTRL, 16'h0001, rej);
        arst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #2;
        check_val(18'(zero_hi), 18'h00001, "second reset zero level");
        check_val(18'(lines), 18'h00000, "second reset line count");
        report_and_stop();
    end
endmodule : tb_lcd_gamma_window_scroll_regs
